/* File: mpfc_consts.vh */
/*
  Constants of the monitor pin function control block: register offsets,
  field positions, reset values and timing figures.
  Assumes inclusion by bare name from the design files of this block.
*/
`ifndef MPFC_CONSTS_VH
`define MPFC_CONSTS_VH

// ----------------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------------
`define MPFC_OFF_CONFIG 8'h00
`define MPFC_OFF_CTRL 8'h04
`define MPFC_OFF_PINSEL 8'h08
`define MPFC_OFF_IDDIV 8'h0C
`define MPFC_OFF_FIFTHID 8'h10
`define MPFC_OFF_STATUS 8'h14
`define MPFC_OFF_MASK 8'h18
`define MPFC_OFF_STRAP 8'h1C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define MPFC_CFG_INT_EN 1
`define MPFC_CFG_RST_EN 4
`define MPFC_CTRL_RST_GO 0
`define MPFC_CTRL_ALERT 1
`define MPFC_CTRL_DIODE2 2
`define MPFC_ST_EXTRST 5
`define MPFC_ST_PULSE_DONE 6
`define MPFC_STRAP_TEST 0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define MPFC_RST_CONFIG 8'h00
`define MPFC_RST_CTRL 8'h00
`define MPFC_RST_PINSEL 8'h00
`define MPFC_RST_FANDIV 4'h0
`define MPFC_RST_MASK 8'h00

// ----------------------------------------------------------------------
// bus answers and timing
// ----------------------------------------------------------------------
`define MPFC_RESP_OKAY 2'b00
`define MPFC_RESP_SLVERR 2'b10
`define MPFC_CLK_PERIOD_NS 10
`define MPFC_TICK_NS 1000
`define MPFC_TICK_CYCLES (`MPFC_TICK_NS / `MPFC_CLK_PERIOD_NS)
`define MPFC_RST_MIN_MS 45
`define MPFC_RST_MIN_TICKS (`MPFC_RST_MIN_MS * 1000000 / `MPFC_TICK_NS)
`define MPFC_STRAP_SETTLE 2'h3

`endif

/* File: mpfc_sync.v */
/*
  Two flip-flop synchroniser for a group of pin levels.
  Assumes levels that stay stable for several clock cycles.
*/
`timescale 1ns/1ps

module mpfc_sync #(
  parameter WIDTH = 1
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // levels
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);

reg [WIDTH-1:0] stage1_q;
reg [WIDTH-1:0] stage2_q;

always @(posedge clk)
begin
  if (!reset_n)
  begin
    stage1_q <= {WIDTH{1'b1}};
    stage2_q <= {WIDTH{1'b1}};
  end
  else
  begin
    stage1_q <= asyncIn;
    stage2_q <= stage1_q;
  end
end

assign syncOut = stage2_q;

endmodule // mpfc_sync

/* File: mpfc_pin_ctrl.v */
/*
  Pin function control of a hardware monitor: interrupt / alert pin, master
  reset pin, test strap, address strap, dual purpose id / interrupt inputs
  and the second analog pair select, with an AXI4-Lite register slave.
  Assumes pads that split each two-way pin into in, out and enable, and a
  pad sense pair for the three-level address strap.
*/
// The register offsets and the AXI4-Lite slave port were left to the implementer.
// Operation
// - the interrupt pin is an active-low open-drain driver enabled only by config bit 1, which resets to 0.
// - the interrupt pin may instead serve as the active-low bus alert output.
// - the test strap held high at power-up enters the connectivity test mode, otherwise normal operation.
// - the master reset output is an active-low open-drain pulse of at least 45 ms.
// - the reset pulse is made only while config bit 4 is set, else the pin is left undriven.
// - the reset pin pulled low from outside acts as a power-on reset input.
// - each of the five dual-purpose inputs is chosen as a voltage code input or an interrupt input.
// - the five code inputs are read through the id and divisor register and the fifth bit register.
// - a select routes the second analog pair to supply monitoring or to the second remote diode.
// - the address strap sets the two low address bits: 01 high, 10 low, 00 floating.
// - in test mode the address pin turns to an output carrying the test chain result.
`timescale 1ns/1ps
`include "mpfc_consts.vh"

module mpfc_pin_ctrl #(
  parameter RST_TICKS = `MPFC_RST_MIN_TICKS + 1,
  parameter TICK_CYCLES = `MPFC_TICK_CYCLES
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // axi4-lite write address and data
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // axi4-lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // axi4-lite read
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // interrupt / alert pin
  output wire intPinOut,
  output wire intPinOe,
  input wire alertAck,
  output wire irq,
  // master reset pin
  input wire resetPinIn,
  output wire resetPinOut,
  output wire resetPinOe,
  output wire deviceReset_n,
  // test strap and address strap pin
  input wire test_mode_strap_in,
  input wire addrSenseHigh,
  input wire addrSenseLow,
  output wire test_chain_out,
  output wire test_chain_oe,
  output wire [1:0] addrLowBits,
  output wire testMode,
  // dual purpose inputs and analog select
  input wire [4:0] processor_voltage_code_in,
  output wire [4:0] external_irq_in_sel,
  output wire diode2Select
);

// ----------------------------------------------------------------------
// states and decode
// ----------------------------------------------------------------------
localparam [1:0] ST_IDLE = 2'b01;
localparam [1:0] ST_PULSE = 2'b10;
localparam [3:0] IDX_NONE = 4'hF;

function [3:0] regIndex;
  input [7:0] addr;
  begin
    if (addr == `MPFC_OFF_CONFIG) regIndex = 4'h0;
    else if (addr == `MPFC_OFF_CTRL) regIndex = 4'h1;
    else if (addr == `MPFC_OFF_PINSEL) regIndex = 4'h2;
    else if (addr == `MPFC_OFF_IDDIV) regIndex = 4'h3;
    else if (addr == `MPFC_OFF_FIFTHID) regIndex = 4'h4;
    else if (addr == `MPFC_OFF_STATUS) regIndex = 4'h5;
    else if (addr == `MPFC_OFF_MASK) regIndex = 4'h6;
    else if (addr == `MPFC_OFF_STRAP) regIndex = 4'h7;
    else regIndex = IDX_NONE;
  end
endfunction

// ----------------------------------------------------------------------
// pin synchronisers
// ----------------------------------------------------------------------
wire [9:0] pinSync;

mpfc_sync #(
  .WIDTH(10)
) uSync (
  .clk(clk),
  .reset_n(reset_n),
  .asyncIn({addrSenseLow, addrSenseHigh, test_mode_strap_in, resetPinIn, processor_voltage_code_in, 1'b0}),
  .syncOut(pinSync)
);

wire [4:0] codeSync = pinSync[5:1];
wire resetPinSync = pinSync[6];
wire strapSync = pinSync[7];
wire addrHighSync = pinSync[8];
wire addrLowSync = pinSync[9];

// ----------------------------------------------------------------------
// registers
// ----------------------------------------------------------------------
reg awReady_q, wReady_q, bValid_q, arReady_q, rValid_q;
reg awHeld_q, wHeld_q;
reg [7:0] awAddr_q;
reg [7:0] wData_q;
reg wLane0_q;
reg [1:0] bResp_q, rResp_q;
reg [31:0] rData_q;
reg [7:0] config_q, ctrl_q, mask_q, status_q;
reg [4:0] pinSel_q;
reg [3:0] fanDiv_q;
reg [4:0] codePrev_q;
reg [1:0] state_q;
reg [7:0] tickCnt_q;
reg [23:0] pulseCnt_q;
reg rstGo_q;
reg [2:0] driveHist_q;
reg extLow_q;
reg [1:0] strapWait_q;
reg strapDone_q, testMode_q;
reg [1:0] addrBits_q;
reg intOe_q, alert_q, irq_q, chainOut_q, chainOe_q;
reg pendPrev_q;

wire writeFire = awHeld_q & wHeld_q & ~bValid_q;
wire [3:0] wIdx = regIndex(awAddr_q);
wire wrOk = writeFire & wLane0_q & (wIdx != IDX_NONE);
wire tick = (tickCnt_q == TICK_CYCLES - 1);
wire [7:0] pending = status_q & mask_q;

// ----------------------------------------------------------------------
// axi4-lite slave
// ----------------------------------------------------------------------
always @(posedge clk)
begin
  if (!reset_n)
  begin
    awReady_q <= 1'b0;
    wReady_q <= 1'b0;
    awHeld_q <= 1'b0;
    wHeld_q <= 1'b0;
    bValid_q <= 1'b0;
    bResp_q <= `MPFC_RESP_OKAY;
    awAddr_q <= 8'h00;
    wData_q <= 8'h00;
    wLane0_q <= 1'b0;
  end
  else
  begin
    if (s_axi_awvalid && awReady_q)
    begin
      awHeld_q <= 1'b1;
      awReady_q <= 1'b0;
      awAddr_q <= s_axi_awaddr;
    end
    else if (!awHeld_q && !bValid_q)
    begin
      awReady_q <= 1'b1;
    end
    if (s_axi_wvalid && wReady_q)
    begin
      wHeld_q <= 1'b1;
      wReady_q <= 1'b0;
      wData_q <= s_axi_wdata[7:0];
      wLane0_q <= s_axi_wstrb[0];
    end
    else if (!wHeld_q && !bValid_q)
    begin
      wReady_q <= 1'b1;
    end
    if (writeFire)
    begin
      bValid_q <= 1'b1;
      awHeld_q <= 1'b0;
      wHeld_q <= 1'b0;
      bResp_q <= (wIdx == IDX_NONE) ? `MPFC_RESP_SLVERR : `MPFC_RESP_OKAY;
    end
    else if (bValid_q && s_axi_bready)
    begin
      bValid_q <= 1'b0;
    end
  end
end

always @(posedge clk)
begin
  if (!reset_n)
  begin
    arReady_q <= 1'b0;
    rValid_q <= 1'b0;
    rData_q <= 32'h00000000;
    rResp_q <= `MPFC_RESP_OKAY;
  end
  else if (s_axi_arvalid && arReady_q)
  begin
    arReady_q <= 1'b0;
    rValid_q <= 1'b1;
    rResp_q <= `MPFC_RESP_OKAY;
    case (regIndex(s_axi_araddr))
      4'h0: rData_q <= {24'h000000, config_q};
      4'h1: rData_q <= {24'h000000, ctrl_q};
      4'h2: rData_q <= {27'h0000000, pinSel_q};
      4'h3: rData_q <= {24'h000000, fanDiv_q, codeSync[3:0]};
      4'h4: rData_q <= {31'h00000000, codeSync[4]};
      4'h5: rData_q <= {24'h000000, status_q};
      4'h6: rData_q <= {24'h000000, mask_q};
      4'h7: rData_q <= {29'h00000000, addrBits_q, testMode_q};
      default:
      begin
        rData_q <= 32'h00000000;
        rResp_q <= `MPFC_RESP_SLVERR;
      end
    endcase
  end
  else if (rValid_q && s_axi_rready)
  begin
    rValid_q <= 1'b0;
    arReady_q <= 1'b1;
  end
  else if (!rValid_q)
  begin
    arReady_q <= 1'b1;
  end
end

// ----------------------------------------------------------------------
// software registers
// ----------------------------------------------------------------------
always @(posedge clk)
begin
  if (!reset_n)
  begin
    config_q <= `MPFC_RST_CONFIG;
    ctrl_q <= `MPFC_RST_CTRL;
    pinSel_q <= 5'h00;
    fanDiv_q <= `MPFC_RST_FANDIV;
    mask_q <= `MPFC_RST_MASK;
    rstGo_q <= 1'b0;
  end
  else
  begin
    rstGo_q <= wrOk && (wIdx == 4'h1) && wData_q[`MPFC_CTRL_RST_GO];
    if (wrOk && wIdx == 4'h0) config_q <= wData_q;
    if (wrOk && wIdx == 4'h1) ctrl_q <= {wData_q[7:1], 1'b0};
    if (wrOk && wIdx == 4'h2) pinSel_q <= wData_q[4:0];
    if (wrOk && wIdx == 4'h3) fanDiv_q <= wData_q[7:4];
    if (wrOk && wIdx == 4'h6) mask_q <= wData_q;
  end
end

// ----------------------------------------------------------------------
// sticky status, set wins over write-one-to-clear
// ----------------------------------------------------------------------
wire [4:0] irqFall = codePrev_q & ~codeSync & pinSel_q;
wire extLowNow = ~resetPinSync & ~(|driveHist_q) & (state_q == ST_IDLE);
wire pulseDone = (state_q == ST_PULSE) & tick & (pulseCnt_q == RST_TICKS - 1);
// bit 7 unused, bit 6 pulse done, bit 5 outside reset seen, bits 4:0 interrupt inputs
wire [7:0] events = {1'b0, pulseDone, ~extLow_q & extLowNow, irqFall};

always @(posedge clk)
begin
  if (!reset_n)
  begin
    status_q <= 8'h00;
    codePrev_q <= 5'h1F;
    extLow_q <= 1'b0;
    driveHist_q <= 3'h0;
  end
  else
  begin
    status_q <= (status_q & ~((wrOk && wIdx == 4'h5) ? wData_q : 8'h00)) | events;
    codePrev_q <= codeSync;
    extLow_q <= extLowNow;
    driveHist_q <= {driveHist_q[1:0], state_q == ST_PULSE};
  end
end

// ----------------------------------------------------------------------
// master reset pulse
// ----------------------------------------------------------------------
always @(posedge clk)
begin
  if (!reset_n)
  begin
    state_q <= ST_IDLE;
    tickCnt_q <= 8'h00;
    pulseCnt_q <= 24'h000000;
  end
  else
  begin
    tickCnt_q <= tick ? 8'h00 : tickCnt_q + 8'h01;
    case (state_q)
      ST_IDLE:
      begin
        pulseCnt_q <= 24'h000000;
        if (rstGo_q && config_q[`MPFC_CFG_RST_EN])
          state_q <= ST_PULSE;
      end
      ST_PULSE:
      begin
        if (!config_q[`MPFC_CFG_RST_EN])
          state_q <= ST_IDLE;
        else if (tick && pulseCnt_q == RST_TICKS - 1)
          state_q <= ST_IDLE;
        else if (tick)
          pulseCnt_q <= pulseCnt_q + 24'h000001;
      end
      default: state_q <= ST_IDLE;
    endcase
  end
end

// ----------------------------------------------------------------------
// straps, test chain and pin drivers
// ----------------------------------------------------------------------
wire [5:0] chain;
assign chain[0] = strapSync;
genvar gi;
generate
  for (gi = 0; gi < 5; gi = gi + 1)
  begin : gChain
    assign chain[gi+1] = ~(chain[gi] & codeSync[gi]);
  end
endgenerate

always @(posedge clk)
begin
  if (!reset_n)
  begin
    strapWait_q <= 2'h0;
    strapDone_q <= 1'b0;
    testMode_q <= 1'b0;
    addrBits_q <= 2'b00;
    intOe_q <= 1'b0;
    alert_q <= 1'b0;
    irq_q <= 1'b0;
    pendPrev_q <= 1'b0;
    chainOut_q <= 1'b0;
    chainOe_q <= 1'b0;
  end
  else
  begin
    if (!strapDone_q)
    begin
      if (strapWait_q == `MPFC_STRAP_SETTLE)
      begin
        strapDone_q <= 1'b1;
        testMode_q <= strapSync;
        if (addrHighSync && !addrLowSync) addrBits_q <= 2'b01;
        else if (addrLowSync && !addrHighSync) addrBits_q <= 2'b10;
        else addrBits_q <= 2'b00;
      end
      else
        strapWait_q <= strapWait_q + 2'h1;
    end
    chainOe_q <= testMode_q;
    chainOut_q <= chain[5];
    pendPrev_q <= |pending;
    irq_q <= |pending;
    if (|pending && !pendPrev_q) alert_q <= 1'b1;
    else if (alertAck || !(|pending)) alert_q <= 1'b0;
    intOe_q <= config_q[`MPFC_CFG_INT_EN] &
               (ctrl_q[`MPFC_CTRL_ALERT] ? alert_q : |pending);
  end
end

// ----------------------------------------------------------------------
// outputs
// ----------------------------------------------------------------------
assign s_axi_awready = awReady_q;
assign s_axi_wready = wReady_q;
assign s_axi_bvalid = bValid_q;
assign s_axi_bresp = bResp_q;
assign s_axi_arready = arReady_q;
assign s_axi_rvalid = rValid_q;
assign s_axi_rdata = rData_q;
assign s_axi_rresp = rResp_q;
assign intPinOut = 1'b0;
assign intPinOe = intOe_q;
assign irq = irq_q;
assign resetPinOut = 1'b0;
assign resetPinOe = driveHist_q[0];
assign deviceReset_n = ~extLow_q;
assign test_chain_out = chainOut_q;
assign test_chain_oe = chainOe_q;
assign addrLowBits = addrBits_q;
assign testMode = testMode_q;
assign external_irq_in_sel = pinSel_q;
assign diode2Select = ctrl_q[`MPFC_CTRL_DIODE2];

endmodule // mpfc_pin_ctrl

/* File: mpfc_asserts.sv */
/*
  Port checker of the monitor pin function control block.
  Assumes binding to mpfc_pin_ctrl with its clock and synchronous reset.
*/
`timescale 1ns/1ps
module mpfc_asserts #(
  parameter RST_TICKS = 3,
  parameter TICK_CYCLES = 4
) (
  // clock and reset
  input wire clk,
  input wire reset_n,
  // read channel
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire s_axi_rvalid,
  // pins
  input wire intPinOut,
  input wire intPinOe,
  input wire resetPinIn,
  input wire resetPinOut,
  input wire resetPinOe,
  input wire deviceReset_n,
  input wire test_chain_oe,
  input wire testMode,
  input wire [1:0] addrLowBits
);
  integer oeLen_q;
  // counts the cycles the reset pin has been driven so far
  always @(posedge clk)
    if (!reset_n)
      oeLen_q <= 0;
    else if (resetPinOe)
      oeLen_q <= oeLen_q + 1;
    else
      oeLen_q <= 0;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_int_pin_low: assert property (intPinOut == 1'b0)
    else $error("interrupt pin drive level is not low");
  a_rst_pin_low: assert property (resetPinOut == 1'b0)
    else $error("reset pin drive level is not low");
  a_rst_pulse_min: assert property ($fell(resetPinOe) |-> oeLen_q >= (RST_TICKS - 1) * TICK_CYCLES)
    else $error("reset pulse too short");
  a_ext_reset: assert property ((!resetPinIn && !resetPinOe) [*6] |-> !deviceReset_n)
    else $error("outside reset not passed on");
  a_self_not_reset: assert property (resetPinOe |-> deviceReset_n)
    else $error("own reset pulse resets the device");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  a_chain_only_test: assert property (test_chain_oe |-> testMode)
    else $error("address pin driven outside test mode");
  a_strap_code: assert property (addrLowBits != 2'b11)
    else $error("address bits hold an impossible code");
  c_rst_pulse: cover property ($rose(resetPinOe));
  c_int_pin: cover property ($rose(intPinOe));
  c_ext_reset: cover property ($fell(deviceReset_n));
endmodule // mpfc_asserts

bind mpfc_pin_ctrl mpfc_asserts #(.RST_TICKS(RST_TICKS), .TICK_CYCLES(TICK_CYCLES)) mpfc_asserts_inst (
  .clk(clk), .reset_n(reset_n), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .intPinOut(intPinOut), .intPinOe(intPinOe), .resetPinIn(resetPinIn),
  .resetPinOut(resetPinOut), .resetPinOe(resetPinOe), .deviceReset_n(deviceReset_n),
  .test_chain_oe(test_chain_oe), .testMode(testMode), .addrLowBits(addrLowBits));

/* File: mpfc_host_model.sv */
/*
  Host side of the interrupt and reset pins: pull-ups and an outside reset.
  Assumes the block's enables mean the pin is pulled low.
*/
`timescale 1ns/1ps
module mpfc_host_model (
  // enables from the block
  input wire intPinOe,
  input wire resetPinOe,
  // host reset request
  input wire hostHoldReset,
  // resolved pin levels
  output wire intPinLevel,
  output wire resetPinLevel
);
  // released pins float up to the pull-up level
  assign intPinLevel = intPinOe ? 1'b0 : 1'b1;
  assign resetPinLevel = (resetPinOe || hostHoldReset) ? 1'b0 : 1'b1;
endmodule // mpfc_host_model

/* File: testbench.sv */
/*
  Self-checking bench of the pin function control block over AXI4-Lite.
  Assumes mpfc_pin_ctrl, mpfc_host_model and the bound checker.
*/
`timescale 1ns/1ps
`include "mpfc_consts.vh"
module testbench;
  localparam RT = 3;
  localparam TC = 4;
  logic clk, resetN, awv, wv, bRdy, arv, rRdy, ack, hostRst, strap, senseHi, senseLo;
  logic [7:0] awa, ara;
  logic [31:0] wd, rdData;
  logic [1:0] rdResp, wrResp;
  logic [4:0] code;
  wire awr, wr, bv, arr, rv, intOut, intOe, irq, rstIn, rstOut, rstOe, devRstN, chainOut, chainOe, testMode, d2;
  wire intLvl;
  wire [1:0] br, rr, addrBits;
  wire [31:0] rd;
  wire [4:0] irqSel;
  integer fails, nTests, n, w;
  mpfc_pin_ctrl #(.RST_TICKS(RT), .TICK_CYCLES(TC)) mpfc_pin_ctrl_inst (.clk(clk), .reset_n(resetN),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bRdy),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr),
    .s_axi_rvalid(rv), .s_axi_rready(rRdy), .intPinOut(intOut), .intPinOe(intOe), .alertAck(ack), .irq(irq),
    .resetPinIn(rstIn), .resetPinOut(rstOut), .resetPinOe(rstOe), .deviceReset_n(devRstN),
    .test_mode_strap_in(strap), .addrSenseHigh(senseHi), .addrSenseLow(senseLo), .test_chain_out(chainOut),
    .test_chain_oe(chainOe), .addrLowBits(addrBits), .testMode(testMode), .processor_voltage_code_in(code),
    .external_irq_in_sel(irqSel), .diode2Select(d2));
  mpfc_host_model mpfc_host_model_inst (.intPinOe(intOe), .resetPinOe(rstOe), .hostHoldReset(hostRst),
    .intPinLevel(intLvl), .resetPinLevel(rstIn));
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", nTests, fails);
    if (fails == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp)
    begin
      $display("BAD %s expected %h seen %h", name, exp, got);
      fails++;
    end
  endtask
  task automatic timedOut;
    fails++;
    print_verdict;
  endtask
  // ----------------------------------------------------------------------
  // bus cycles: each channel released at the edge it is taken
  // ----------------------------------------------------------------------
  task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
    awa <= a; wd <= d; awv <= 1; wv <= 1; bRdy <= 1; n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (awv && awr) awv <= 0;
      if (wv && wr) wv <= 0;
    end while (!(bv && !awv && !wv) && n < 100);
    if (n >= 100) timedOut;
    wrResp = br;
    bRdy <= 0;
    @(posedge clk);
  endtask
  task automatic axiRd(input logic [7:0] a);
    ara <= a; arv <= 1; rRdy <= 1; n = 0;
    do
    begin
      @(posedge clk);
      n++;
      if (arv && arr) arv <= 0;
    end while (!(rv && !arv) && n < 100);
    if (n >= 100) timedOut;
    rdData = rd; rdResp = rr; rRdy <= 0;
    @(posedge clk);
  endtask
  task automatic doReset(input logic s, input logic hi, input logic lo);
    resetN <= 0; strap <= s; senseHi <= hi; senseLo <= lo;
    repeat (20) @(posedge clk);
    resetN <= 1;
    repeat (8) @(posedge clk);
  endtask
  initial
  begin
    fails = 0; nTests = 0; resetN = 0; awv = 0; wv = 0; bRdy = 0; arv = 0; rRdy = 0; ack = 0; hostRst = 0;
    awa = 8'h00; ara = 8'h00; wd = 32'h0; code = 5'h15; strap = 0; senseHi = 1; senseLo = 0;
    doReset(1'b0, 1'b1, 1'b0);
    chk("testMode", 0, testMode);
    chk("addrBits", 2'h1, addrBits);
    axiRd(`MPFC_OFF_CONFIG); chk("config", 32'h0, rdData);
    axiRd(8'h20); chk("unmappedResp", `MPFC_RESP_SLVERR, rdResp);
    axiRd(`MPFC_OFF_IDDIV); chk("codeLow", 4'h5, rdData[3:0]);
    axiRd(`MPFC_OFF_FIFTHID); chk("codeHigh", 1, rdData[0]);
    axiWr(8'h24, 32'hFF); chk("unmappedWrResp", `MPFC_RESP_SLVERR, wrResp);
    axiWr(`MPFC_OFF_PINSEL, 32'h1F); chk("irqSelAll", 5'h1F, irqSel);
    chk("pinselWrResp", `MPFC_RESP_OKAY, wrResp);
    axiWr(`MPFC_OFF_PINSEL, 32'h01); chk("irqSelOne", 5'h01, irqSel);
    axiWr(`MPFC_OFF_CTRL, 32'h04); chk("diode2", 1, d2);
    axiWr(`MPFC_OFF_MASK, 32'h01);
    code <= 5'h14;
    repeat (6) @(posedge clk);
    chk("irqSet", 1, irq); chk("intOeOff", 0, intOe);
    axiWr(`MPFC_OFF_CONFIG, 32'h02); repeat (3) @(posedge clk);
    chk("intOeOn", 1, intOe); chk("intLevel", 0, intLvl);
    axiWr(`MPFC_OFF_STATUS, 32'h01); repeat (3) @(posedge clk);
    chk("irqClear", 0, irq); chk("intOeClear", 0, intOe);
    axiWr(`MPFC_OFF_CTRL, 32'h06);
    code <= 5'h15; repeat (6) @(posedge clk);
    code <= 5'h14; repeat (6) @(posedge clk);
    chk("alertOn", 1, intOe);
    ack <= 1; @(posedge clk); ack <= 0; repeat (3) @(posedge clk);
    chk("alertAck", 0, intOe);
    axiWr(`MPFC_OFF_STATUS, 32'h01);
    axiWr(`MPFC_OFF_CTRL, 32'h05); repeat (RT * TC + 10) @(posedge clk);
    chk("rstOeOff", 0, rstOe);
    axiWr(`MPFC_OFF_CONFIG, 32'h10);
    axiWr(`MPFC_OFF_CTRL, 32'h05);
    n = 0; while (!rstOe && n < 20) begin @(posedge clk); n++; end
    chk("rstOeOn", 1, rstOe);
    w = 0; while (rstOe && w < 200) begin @(posedge clk); w++; end
    chk("rstWidth", 1, w >= (RT - 1) * TC && w < 200);
    chk("selfNoReset", 1, devRstN);
    hostRst <= 1; repeat (6) @(posedge clk);
    chk("extReset", 0, devRstN);
    hostRst <= 0; repeat (8) @(posedge clk);
    chk("extRelease", 1, devRstN);
    axiRd(`MPFC_OFF_STATUS); chk("statusPulseExt", 32'h60, rdData);
    doReset(1'b1, 1'b0, 1'b1);
    chk("testModeOn", 1, testMode);
    chk("addrBitsLow", 2'h2, addrBits);
    chk("chainOe", 1, chainOe);
    print_verdict;
  end
endmodule // testbench
